// ---- hw/rx_cfg_regs.sv ----
// Per-port receive mask, signaling enable and loop code registers
`timescale 1ns/1ps
module rx_cfg_regs (
	input  wire logic          mclk,
	input  wire logic          sys_rst,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [14:0]   wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	input  wire logic [7:0]    rx_bit,
	input  wire logic [7:0]    rx_bit_valid,
	input  wire logic [7:0]    boc_event,
	input  wire logic [7:0]    sa6_event,
	input  wire logic [7:0]    sax_event,
	input  wire logic [255:0]  sig_state_change,
	output logic               irq,
	output logic [7:0]         signaling_change_flag,
	output logic [7:0]         loop_up_seen,
	output logic [7:0]         loop_down_seen
);
	import rx_cfg_pkg::*;

	typedef struct packed {
		logic [NUM_PORTS-1:0][10:0][7:0] regs;    // Stored registers
		logic [NUM_PORTS-1:0]            rst_up;  // Up detector restart
		logic [NUM_PORTS-1:0]            rst_dn;  // Down detector restart
		logic [IRQ_W-1:0]                clr;     // Status clear pulse
		logic                            ack;     // Bus ack
		logic [7:0]                      dat;     // Read data
		logic [NUM_PORTS-1:0]            sig;     // Signaling flag
		logic [NUM_PORTS-1:0]            up;      // Loop-up seen
		logic [NUM_PORTS-1:0]            dn;      // Loop-down seen
	} top_state_t;

	top_state_t state;      // Registered state
	top_state_t next_state; // Next state

	logic [NUM_PORTS-1:0] up_hit;  // Detector outputs
	logic [NUM_PORTS-1:0] dn_hit;
	logic [IRQ_W-1:0]     ev_set;  // Events this cycle
	logic [IRQ_W-1:0]     ev_gate; // Enable and mask
	logic [IRQ_W-1:0]     ev_stat; // Sticky status
	logic                 irq_lvl; // Interrupt flop
	logic [NUM_PORTS-1:0] sig_ev;  // Signaling change now

	// Offset to slot; used for both read and write decode
	function automatic slot_t slot_of(input logic [8:0] off);
		if (off == OFF_SA_MASK) begin
			slot_of = SLOT_MASK;
		end else if (off == OFF_SIG_EN1) begin
			slot_of = SLOT_SIG1;
		end else if (off == OFF_SIG_EN2) begin
			slot_of = SLOT_SIG2;
		end else if (off == OFF_SIG_EN3) begin
			slot_of = SLOT_SIG3;
		end else if (off == OFF_SIG_EN4) begin
			slot_of = SLOT_SIG4;
		end else if (off == OFF_UP1) begin
			slot_of = SLOT_UP1;
		end else if (off == OFF_UP2) begin
			slot_of = SLOT_UP2;
		end else if (off == OFF_DN1) begin
			slot_of = SLOT_DN1;
		end else if (off == OFF_DN2) begin
			slot_of = SLOT_DN2;
		end else if (off == OFF_CTRL) begin
			slot_of = SLOT_CTRL;
		end else if (off == OFF_ENABLE) begin
			slot_of = SLOT_EN;
		end else if (off == OFF_STATUS) begin
			slot_of = SLOT_STAT;
		end else if (off == OFF_CLEAR) begin
			slot_of = SLOT_CLR;
		end else begin
			slot_of = SLOT_NONE;
		end
	endfunction : slot_of

	// Bus word index: port window times stride plus offset
	logic [12:0] idx;      // Register index
	logic [2:0]  acc_port; // Addressed port
	logic [8:0]  acc_off;  // Offset in window
	slot_t       acc_slot; // Decoded slot
	logic        req;      // New request

	assign idx      = wb_adr_i[14:2];
	assign acc_port = idx[11:9];
	assign acc_off  = idx[8:0];
	assign acc_slot = (idx[12] == 1'b0) ? slot_of(acc_off) : SLOT_NONE;
	assign req      = wb_cyc_i & wb_stb_i & ~state.ack;

	// Per-port event sources and gates
	generate
		for (genvar p = 0; p < NUM_PORTS; p++) begin : g_ev
			logic       e1;     // Port in E1 mode
			logic [7:0] mask;   // Sa/BOC mask register
			logic [31:0] ch_en; // Channel enables
			assign e1   = state.regs[p][SLOT_CTRL][CTRL_E1_BIT];
			assign mask = state.regs[p][SLOT_MASK];
			// fourth byte counts only in E1
			assign ch_en = {(e1 ? state.regs[p][SLOT_SIG4] : 8'h00), state.regs[p][SLOT_SIG3],
				state.regs[p][SLOT_SIG2], state.regs[p][SLOT_SIG1]};
			assign sig_ev[p] = |(sig_state_change[p*32 +: 32] & ch_en);
			// Low event is BOC in T1, SaX change in E1
			assign ev_set[p*ST_W + ST_LOW]  = e1 ? sax_event[p] : boc_event[p];
			assign ev_set[p*ST_W + ST_SA6]  = e1 & sa6_event[p];
			assign ev_set[p*ST_W + ST_SIG]  = sig_ev[p];
			assign ev_set[p*ST_W + ST_UP]   = up_hit[p] & ~state.up[p];
			assign ev_set[p*ST_W + ST_DOWN] = dn_hit[p] & ~state.dn[p];
			assign ev_gate[p*ST_W + ST_LOW] = state.regs[p][SLOT_EN][ST_LOW] & mask[MASK_LOW_BIT];
			assign ev_gate[p*ST_W + ST_SA6] = state.regs[p][SLOT_EN][ST_SA6] & e1 & mask[MASK_SA6_BIT];
			assign ev_gate[p*ST_W + ST_SIG]  = state.regs[p][SLOT_EN][ST_SIG];
			assign ev_gate[p*ST_W + ST_UP]   = state.regs[p][SLOT_EN][ST_UP];
			assign ev_gate[p*ST_W + ST_DOWN] = state.regs[p][SLOT_EN][ST_DOWN];
		end
	endgenerate

	// Loop code detectors, one pair per port
	generate
		for (genvar p = 0; p < NUM_PORTS; p++) begin : g_det
			code_det_if up_if ();
			code_det_if dn_if ();
			assign up_if.len_m1   = state.regs[p][SLOT_CTRL][CTRL_LEN_LSB +: 4];
			assign dn_if.len_m1   = state.regs[p][SLOT_CTRL][CTRL_LEN_LSB +: 4];
			// First byte holds the leading bits
			assign up_if.pattern  = {state.regs[p][SLOT_UP1], state.regs[p][SLOT_UP2]};
			assign dn_if.pattern  = {state.regs[p][SLOT_DN1], state.regs[p][SLOT_DN2]};
			assign up_if.restart  = state.rst_up[p];
			assign dn_if.restart  = state.rst_dn[p];
			assign up_if.rx_bit   = rx_bit[p];
			assign dn_if.rx_bit   = rx_bit[p];
			assign up_if.rx_valid = rx_bit_valid[p];
			assign dn_if.rx_valid = rx_bit_valid[p];
			assign up_hit[p]      = up_if.seen;
			assign dn_hit[p]      = dn_if.seen;
			code_detector u_up (
				.mclk    (mclk),
				.sys_rst (sys_rst),
				.link    (up_if.det)
			);
			code_detector u_dn (
				.mclk    (mclk),
				.sys_rst (sys_rst),
				.link    (dn_if.det)
			);
		end
	endgenerate

	// Sticky status and interrupt
	irq_bank u_irq (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.set_ev  (ev_set),
		.clr_ev  (state.clr),
		.gate    (ev_gate),
		.status  (ev_stat),
		.irq     (irq_lvl)
	);

	// Bus access, register writes and flag registers
	always_comb begin
		next_state        = state;
		next_state.ack    = req;
		next_state.rst_up = '0;
		next_state.rst_dn = '0;
		next_state.clr    = '0;
		next_state.sig    = sig_ev;
		next_state.up     = up_hit;
		next_state.dn     = dn_hit;
		if (req && !wb_we_i) begin
			// Read; unmapped and write-only give zero
			if (acc_slot == SLOT_STAT) begin
				next_state.dat = {3'h0, ev_stat[acc_port*ST_W +: ST_W]};
			end else if (acc_slot == SLOT_EN) begin
				next_state.dat = {3'h0, state.regs[acc_port][SLOT_EN][ST_W-1:0]};
			end else if (acc_slot <= SLOT_CTRL) begin
				next_state.dat = state.regs[acc_port][acc_slot];
			end else begin
				next_state.dat = 8'h00;
			end
		end else if (req && wb_sel_i[0]) begin
			// Write on the low byte lane only
			next_state.dat = 8'h00;
			if (acc_slot == SLOT_CLR) begin
				next_state.clr[acc_port*ST_W +: ST_W] = wb_dat_i[ST_W-1:0];
			end else if (acc_slot == SLOT_EN) begin
				next_state.regs[acc_port][SLOT_EN] = {3'h0, wb_dat_i[ST_W-1:0]};
			end else if (acc_slot <= SLOT_CTRL) begin
				next_state.regs[acc_port][acc_slot] = wb_dat_i[7:0];
			end
			// restart detector on first byte write
			if (acc_slot == SLOT_UP1) begin
				next_state.rst_up[acc_port] = 1'b1;
			end
			if (acc_slot == SLOT_DN1) begin
				next_state.rst_dn[acc_port] = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from flops
	assign wb_ack_o              = state.ack;
	assign wb_dat_o              = {24'h000000, state.dat};
	assign irq                   = irq_lvl;
	assign signaling_change_flag = state.sig;
	assign loop_up_seen          = state.up;
	assign loop_down_seen        = state.dn;
endmodule : rx_cfg_regs

// ---- common/rx_cfg_pkg.sv ----
// Constants and types shared by the receive configuration register group
package rx_cfg_pkg;
	// Port count and per-port register window, in register indices
	localparam int          NUM_PORTS   = 8;
	localparam logic [12:0] PORT_STRIDE = 13'h0200;
	// Offsets inside one port window
	localparam logic [8:0]  OFF_SA_MASK = 9'h0a6;
	localparam logic [8:0]  OFF_SIG_EN1 = 9'h0a8;
	localparam logic [8:0]  OFF_SIG_EN2 = 9'h0a9;
	localparam logic [8:0]  OFF_SIG_EN3 = 9'h0aa;
	localparam logic [8:0]  OFF_SIG_EN4 = 9'h0ab;
	localparam logic [8:0]  OFF_UP1     = 9'h0ac;
	localparam logic [8:0]  OFF_UP2     = 9'h0ad;
	localparam logic [8:0]  OFF_DN1     = 9'h0ae;
	localparam logic [8:0]  OFF_DN2     = 9'h0af;
	localparam logic [8:0]  OFF_CTRL    = 9'h1c0;
	localparam logic [8:0]  OFF_STATUS  = 9'h1c1;
	localparam logic [8:0]  OFF_CLEAR   = 9'h1c2;
	localparam logic [8:0]  OFF_ENABLE  = 9'h1c3;
	// Reset value of every register
	localparam logic [7:0]  REG_RESET   = 8'h00;
	// Field positions
	localparam int          MASK_LOW_BIT = 0;
	localparam int          MASK_SA6_BIT = 1;
	localparam int          CTRL_E1_BIT  = 0;
	localparam int          CTRL_LEN_LSB = 4;
	localparam int          ST_LOW   = 0;
	localparam int          ST_SA6   = 1;
	localparam int          ST_SIG   = 2;
	localparam int          ST_UP    = 3;
	localparam int          ST_DOWN  = 4;
	localparam int          ST_W     = 5;
	localparam int          IRQ_W    = NUM_PORTS * ST_W;
	// Matching bits needed before a code counts as received
	localparam logic [15:0] INTEG_BITS = 16'h0030;
	// Register slots of one port
	typedef enum logic [3:0] {
		SLOT_MASK = 4'h0, SLOT_SIG1 = 4'h1, SLOT_SIG2 = 4'h2, SLOT_SIG3 = 4'h3,
		SLOT_SIG4 = 4'h4, SLOT_UP1 = 4'h5, SLOT_UP2 = 4'h6, SLOT_DN1 = 4'h7,
		SLOT_DN2 = 4'h8, SLOT_CTRL = 4'h9, SLOT_EN = 4'ha, SLOT_STAT = 4'hb,
		SLOT_CLR = 4'hc, SLOT_NONE = 4'hf
	} slot_t;
endpackage : rx_cfg_pkg

// ---- common/code_det_if.sv ----
// Link between register logic and one repeating-code detector
`timescale 1ns/1ps
interface code_det_if;
	logic [15:0] pattern;  // Bit 15 sent first
	logic [3:0]  len_m1;   // Pattern length minus one
	logic        restart;  // Restart integration
	logic        rx_bit;   // Received bit
	logic        rx_valid; // Bit strobe
	logic        seen;     // Code being received
	modport ctl (output pattern, len_m1, restart, rx_bit, rx_valid, input seen);
	modport det (input pattern, len_m1, restart, rx_bit, rx_valid, output seen);
endinterface : code_det_if

// ---- hw/code_detector.sv ----
// Repeating-code detector with integration counter
`timescale 1ns/1ps
module code_detector (
	input wire logic mclk,
	input wire logic sys_rst,
	code_det_if.det  link
);
	import rx_cfg_pkg::*;

	typedef struct packed {
		logic [3:0]  phase; // Position in pattern
		logic [15:0] count; // Consecutive matches
		logic        seen;  // Detected
	} det_state_t;

	det_state_t state;      // Registered state
	det_state_t next_state; // Next state

	// Match and integrate
	always_comb begin
		next_state = state;
		if (link.restart) begin
			next_state = '0;
		end else if (link.rx_valid) begin
			// first bit leads, short lengths skip low bits
			// second byte unused below eight bits
			if (link.rx_bit == link.pattern[4'hf - state.phase]) begin
				next_state.phase = (state.phase == link.len_m1) ? 4'h0 : state.phase + 4'h1;
				if (state.count != INTEG_BITS) begin
					next_state.count = state.count + 16'h0001;
				end
			end else if (link.rx_bit == link.pattern[15]) begin
				// Resync on the first bit only; a start that began inside the failed partial match is missed
				next_state.phase = (link.len_m1 == 4'h0) ? 4'h0 : 4'h1;
				next_state.count = 16'h0001;
			end else begin
				next_state.phase = 4'h0;
				next_state.count = 16'h0000;
			end
			next_state.seen = (next_state.count == INTEG_BITS);
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign link.seen = state.seen;
endmodule : code_detector

// ---- hw/irq_bank.sv ----
// Sticky event status with enable gating onto one interrupt
`timescale 1ns/1ps
module irq_bank (
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	input  wire logic [rx_cfg_pkg::IRQ_W-1:0] set_ev,
	input  wire logic [rx_cfg_pkg::IRQ_W-1:0] clr_ev,
	input  wire logic [rx_cfg_pkg::IRQ_W-1:0] gate,
	output logic      [rx_cfg_pkg::IRQ_W-1:0] status,
	output logic                             irq
);
	import rx_cfg_pkg::*;

	typedef struct packed {
		logic [IRQ_W-1:0] status; // Sticky bits
		logic             irq;    // Interrupt level
	} irq_state_t;

	irq_state_t state;      // Registered state
	irq_state_t next_state; // Next state

	// Set beats clear in the same cycle so no event is lost
	always_comb begin
		next_state.status = (state.status & ~clr_ev) | set_ev;
		next_state.irq    = |(next_state.status & gate);
	end

	// State register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign status = state.status;
	assign irq    = state.irq;
endmodule : irq_bank

// ---- verification/rx_cfg_regs_chk.sv ----
// Port-level timing checks for the receive config registers
`timescale 1ns/1ps
module rx_cfg_regs_chk
	import rx_cfg_pkg::*;
(
	input wire logic         mclk,
	input wire logic         sys_rst,
	input wire logic         wb_cyc_i,
	input wire logic         wb_stb_i,
	input wire logic         wb_we_i,
	input wire logic [14:0]  wb_adr_i,
	input wire logic [3:0]   wb_sel_i,
	input wire logic [31:0]  wb_dat_o,
	input wire logic         wb_ack_o,
	input wire logic [255:0] sig_state_change,
	input wire logic         irq,
	input wire logic [7:0]   signaling_change_flag,
	input wire logic [7:0]   loop_up_seen,
	input wire logic [7:0]   loop_down_seen
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// New write of port 0 at one offset
	sequence s_wr(logic [8:0] off);
		wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[14:2] == {4'h0, off};
	endsequence
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
	a_data_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
	a_data_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
	a_reset_zero: assert property (disable iff (1'b0) sys_rst |=> !wb_ack_o && !irq && signaling_change_flag == 8'h0
		&& loop_up_seen == 8'h0 && loop_down_seen == 8'h0) else $error("output not cleared");
	a_sig_flag_cause: assert property (|signaling_change_flag |-> $past(|sig_state_change)) else $error("flag no cause");
	a_up_restart: assert property (s_wr(OFF_UP1) |-> ##[3:4] !loop_up_seen[0]) else $error("up not restarted");
	a_dn_restart: assert property (s_wr(OFF_DN1) |-> ##[3:4] !loop_down_seen[0]) else $error("dn not restarted");
endmodule : rx_cfg_regs_chk
bind rx_cfg_regs rx_cfg_regs_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.sig_state_change(sig_state_change), .irq(irq), .signaling_change_flag(signaling_change_flag),
	.loop_up_seen(loop_up_seen), .loop_down_seen(loop_down_seen));

// ---- verification/rx_event_mask_loop_code_regs_tb_top.sv ----
// Self-checking bench for the receive config registers
`timescale 1ns/1ps
module rx_event_mask_loop_code_regs_tb_top;
	import rx_cfg_pkg::*;
	logic         mclk = 1'b0;
	logic         sys_rst = 1'b1;
	logic         cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
	logic [14:0]  adr = 15'h0;
	logic [3:0]   sel = 4'h0;
	logic [31:0]  wdat = 32'h0, rdat, q, en;
	logic [7:0]   rx_bit = 8'h0, rx_val = 8'h0, boc = 8'h0, sa6 = 8'h0, sax = 8'h0, sig_flag, up_seen, dn_seen, up1;
	logic [255:0] sig_chg = 256'h0;
	logic [7:0]   mdl [8][9];
	logic [8:0]   offs [9] = '{OFF_SA_MASK, OFF_SIG_EN1, OFF_SIG_EN2, OFF_SIG_EN3, OFF_SIG_EN4,
		OFF_UP1, OFF_UP2, OFF_DN1, OFF_DN2};
	int           err_count = 0, checks = 0, seed = 10656, i, p, k, m;
	// Free-running system clock
	always #4 mclk = ~mclk;
	rx_cfg_regs dut (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_bit(rx_bit), .rx_bit_valid(rx_val),
		.boc_event(boc), .sa6_event(sa6), .sax_event(sax), .sig_state_change(sig_chg), .irq(irq),
		.signaling_change_flag(sig_flag), .loop_up_seen(up_seen), .loop_down_seen(dn_seen));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask : chk
	// One classic cycle; waits on ack, bounded so a dead slave cannot hang us
	task automatic xfer(input logic w, input int pt, input logic [8:0] off, input logic [7:0] d, input logic s0);
		int n;
		n = 0;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= {3'h0, s0};
		wdat <= {24'h0, d};
		adr <= {1'b0, pt[2:0], off, 2'b00};
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		if (n >= 20) err_count++;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : xfer
	// One-cycle event pulse: 0 code, 1 Sa6, 2 Sa change
	task automatic ev(input int kind, input int pt);
		@(posedge mclk);
		if (kind == 0) boc[pt] <= 1'b1;
		else if (kind == 1) sa6[pt] <= 1'b1;
		else sax[pt] <= 1'b1;
		@(posedge mclk);
		boc <= 8'h0;
		sa6 <= 8'h0;
		sax <= 8'h0;
	endtask : ev
	// Repeating 4-bit pattern on port 0, first bit from pattern bit 3
	task automatic send(input int n, input logic [3:0] pat);
		for (int j = 0; j < n; j++) begin
			@(posedge mclk);
			rx_bit[0] <= pat[3 - j % 4];
			rx_val[0] <= 1'b1;
			@(posedge mclk);
			rx_val[0] <= 1'b0;
		end
	endtask : send
	function automatic logic exp_irq(input logic e1, input logic kind, input logic [1:0] mk);
		return kind ? (mk[1] & e1) : mk[0];
	endfunction : exp_irq
	task automatic irq_case(input logic e1, input logic kind, input logic [1:0] mk);
		xfer(1'b1, 3, OFF_CTRL, {7'h0, e1}, 1'b1);
		xfer(1'b1, 3, OFF_SA_MASK, {6'h0, mk}, 1'b1);
		xfer(1'b1, 3, OFF_ENABLE, 8'h1f, 1'b1);
		ev(kind ? 1 : (e1 ? 2 : 0), 3);
		repeat (3) @(posedge mclk);
		chk(irq, exp_irq(e1, kind, mk));
		xfer(1'b0, 3, OFF_STATUS, 8'h0, 1'b0);
		chk(q, kind ? 32'h2 : 32'h1);
		xfer(1'b1, 3, OFF_CLEAR, 8'h1f, 1'b1);
		repeat (2) @(posedge mclk);
		chk(irq, 32'h0);
	endtask : irq_case
	task final_report;
		if (err_count == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report
	// Watchdog well past the expected run length
	initial begin
		#400000;
		err_count++;
		final_report;
	end
	initial begin
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		for (p = 0; p < 8; p++) for (k = 0; k < 9; k++) begin
			xfer(1'b0, p, offs[k], 8'h0, 1'b0);
			chk(q, 32'h0);
			mdl[p][k] = $random(seed);
			xfer(1'b1, p, offs[k], mdl[p][k], 1'b1);
		end
		for (p = 0; p < 8; p++) for (k = 0; k < 9; k++) begin
			xfer(1'b0, p, offs[k], 8'h0, 1'b0);
			chk(q, {24'h0, mdl[p][k]});
		end
		// Lane 0 off drops the write; a hole reads zero
		xfer(1'b1, 5, offs[3], ~mdl[5][3], 1'b0);
		xfer(1'b0, 5, offs[3], 8'h0, 1'b0);
		chk(q, {24'h0, mdl[5][3]});
		xfer(1'b1, 5, 9'h0a7, 8'hff, 1'b1);
		xfer(1'b0, 5, 9'h0a7, 8'h0, 1'b0);
		chk(q, 32'h0);
		for (m = 0; m < 16; m++) if (!(m[2] && !m[3])) irq_case(m[3], m[2], m[1:0]);
		// Channel enables, fourth byte only counts in E1
		for (m = 0; m < 2; m++) begin
			xfer(1'b1, 1, OFF_CTRL, {7'h0, m[0]}, 1'b1);
			en = $random(seed);
			for (k = 0; k < 4; k++) xfer(1'b1, 1, offs[1 + k], en[8 * k +: 8], 1'b1);
			for (i = 0; i < 32; i++) begin
				@(posedge mclk);
				sig_chg[32 + i] <= 1'b1;
				@(posedge mclk);
				sig_chg <= 256'h0;
				#1;
				chk(sig_flag[1], en[i] & (i < 24 | m[0]));
			end
			// Sticky signaling bit must follow any enabled channel
			xfer(1'b0, 1, OFF_STATUS, 8'h0, 1'b0);
			chk(q, {29'h0, |(en & (m[0] ? 32'hffffffff : 32'h00ffffff)), 2'b00});
			xfer(1'b1, 1, OFF_CLEAR, 8'h1f, 1'b1);
		end
		// 4-bit codes: low bits of byte 1 and all of byte 2 are don't care
		xfer(1'b1, 0, OFF_CTRL, 8'h30, 1'b1);
		up1 = 8'ha0 | ($random(seed) & 8'h0f);
		xfer(1'b1, 0, OFF_UP1, up1, 1'b1);
		xfer(1'b1, 0, OFF_UP2, $random(seed), 1'b1);
		xfer(1'b1, 0, OFF_DN1, 8'hc0 | ($random(seed) & 8'h0f), 1'b1);
		xfer(1'b1, 0, OFF_DN2, $random(seed), 1'b1);
		send(40, 4'ha);
		chk(up_seen[0], 32'h0);
		send(24, 4'ha);
		repeat (3) @(posedge mclk);
		chk(up_seen[0], 32'h1);
		chk(dn_seen[0], 32'h0);
		// Only the loop-up rise is latched so far on port 0
		xfer(1'b0, 0, OFF_STATUS, 8'h0, 1'b0);
		chk(q, 32'h8);
		xfer(1'b1, 0, OFF_UP1, up1, 1'b1);
		repeat (3) @(posedge mclk);
		chk(up_seen[0], 32'h0);
		send(64, 4'hc);
		repeat (3) @(posedge mclk);
		chk(dn_seen[0], 32'h1);
		chk(up_seen[0], 32'h0);
		// Loop-down rise now latched beside the earlier loop-up one
		xfer(1'b0, 0, OFF_STATUS, 8'h0, 1'b0);
		chk(q, 32'h18);
		final_report;
	end
endmodule : rx_event_mask_loop_code_regs_tb_top
